// ==== hdl/uart_driver_enable_control.sv ====
// Serial transmit/receive slice with transceiver driver-enable envelope and APB registers
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`include "uart_de_regs.svh"
module uart_driver_enable_control (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic [15:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line and flow control
   output logic txd,
   input wire logic rxd,
   input wire logic cts_b,
   output logic tx_driver_enable,
   // Interrupt requests
   output logic txIrq,
   output logic rxIrq
);
   // Register state
   logic [7:0] serial_control_zero; // Transmit/receive enables and frame format
   logic [7:0] serial_control_one; // Polarity, multiprocessor and timer controls
   logic [15:0] baudDiv; // Sample-tick divisor
   logic sampleTick; // Sixteen ticks per bit period

   // Transmitter state
   uart_de_pkg::tx_state_e txState, next_txState;
   logic [7:0] txHold; // Byte waiting to be sent
   logic txFull; // Holding register occupied
   logic [7:0] txShift; // Byte being sent, LSB first
   logic txParity; // Parity of the byte being sent
   logic [2:0] txBitIdx; // Data bit counter
   logic txSecondStop; // Second stop bit in progress
   logic [4:0] subCnt; // Sample ticks within the current bit

   // Receiver state
   uart_de_pkg::rx_state_e rxState;
   logic [4:0] rxSub; // Sample ticks within the current bit
   logic [2:0] rxBitIdx; // Data bit counter
   logic [7:0] rxShift; // Assembling byte
   logic rxParAcc; // Running parity of received bits
   logic rxParBad; // Parity mismatch of the assembling byte
   logic rxMpBit; // Multiprocessor bit of the assembling byte
   logic [7:0] rxData; // Last complete byte
   logic rxReady, parityErr, framingErr, overrun; // Receive status
   logic first_byte_of_frame_flag; // Current byte opens a new frame
   logic multiproc_bit_received; // Last multiprocessor bit
   logic timerFlag; // Timer expiry while serial function is off
   logic skipClear; // A byte landed at the setup edge of a data read

   // Field decode
   wire logic transmitter_on = serial_control_zero[`UDE_TXON];
   wire logic rxOn = serial_control_zero[`UDE_RXON];
   wire logic clear_to_send_gating = serial_control_zero[`UDE_CTSG];
   wire logic parity_on = serial_control_zero[`UDE_PARON];
   wire logic parOdd = serial_control_zero[`UDE_PARODD];
   wire logic send_break = serial_control_zero[`UDE_BRK];
   wire logic twoStops = serial_control_zero[`UDE_STOP2];
   wire logic loopback_on = serial_control_zero[`UDE_LOOP];
   wire logic driver_enable_polarity = serial_control_one[`UDE_DRIVER_ENABLE_POLARITY];
   wire logic mpOn = serial_control_one[`UDE_MPON];
   wire logic mpSend = serial_control_one[`UDE_MPSEND];
   wire logic timerMode = serial_control_one[`UDE_TIMERON] & ~transmitter_on & ~rxOn;

   // APB decode; the slave never waits
   wire logic [13:0] wordIdx = paddr[15:2];
   wire logic aligned = (paddr[1:0] == 2'h0);
   wire logic hitData = aligned && (wordIdx == `UDE_DATA_IDX);
   wire logic hitStat = aligned && (wordIdx == `UDE_STAT_IDX);
   wire logic hitCtl0 = aligned && (wordIdx == `UDE_CTL0_IDX);
   wire logic hitCtl1 = aligned && (wordIdx == `UDE_CTL1_IDX);
   wire logic hitBaudH = aligned && (wordIdx == `UDE_BAUDH_IDX);
   wire logic hitBaudL = aligned && (wordIdx == `UDE_BAUDL_IDX);
   wire logic anyHit = hitData | hitStat | hitCtl0 | hitCtl1 | hitBaudH | hitBaudL;
   wire logic setupPhase = psel & ~penable;
   wire logic access = psel & penable;
   wire logic wrOk = access & pwrite & anyHit;
   wire logic txWrite = wrOk & hitData;
   wire logic rxRead = access & ~pwrite & hitData & ~skipClear;
   wire logic statRead = access & ~pwrite & hitStat;

   // Transmitter qualifiers
   wire logic ctsOk = ~clear_to_send_gating | ~cts_b;
   wire logic txGo = transmitter_on & txFull & ctsOk;
   wire logic [4:0] bitLast = (txState == uart_de_pkg::TX_SETUP) ? `UDE_SETUP_LAST
                                                                 : `UDE_BIT_LAST;
   wire logic txBitEnd = sampleTick && (subCnt == bitLast);
   wire logic stopEnd = txBitEnd && (txState == uart_de_pkg::TX_STOP) &&
                        (~twoStops | txSecondStop);
   wire logic txLoad = (txState == uart_de_pkg::TX_IDLE && next_txState == uart_de_pkg::TX_SETUP)
                    || (stopEnd && next_txState == uart_de_pkg::TX_START);
   // Envelope is on in every state but idle, including the one-cycle tail
   wire logic deActive = (txState != uart_de_pkg::TX_IDLE);

   // Status word; everything above bit 8 is reserved
   wire logic [31:0] statWord = {23'h000000, timerFlag, multiproc_bit_received,
                                 first_byte_of_frame_flag, overrun, framingErr,
                                 parityErr, ~deActive, ~txFull, rxReady};
   wire logic [31:0] readMux =
      hitData  ? {24'h000000, rxData} :
      hitStat  ? statWord :
      hitCtl0  ? {24'h000000, serial_control_zero} :
      hitCtl1  ? {24'h000000, serial_control_one} :
      hitBaudH ? {24'h000000, baudDiv[15:8]} :
      hitBaudL ? {24'h000000, baudDiv[7:0]} : 32'h00000000;

   // Receive line source, looped back from the transmitter when asked
   wire logic rxIn = loopback_on ? txd : rxd;
   wire logic [4:0] rxLast = (rxState == uart_de_pkg::RX_START) ? `UDE_RX_MID : `UDE_BIT_LAST;
   wire logic rxSample = sampleTick && (rxSub == rxLast);
   wire logic rxStore = rxSample && (rxState == uart_de_pkg::RX_STOP);

   // Baud divider
   uart_baud_tick uart_baud_tick_i (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .divisor(baudDiv),
      .sampleTick(sampleTick)
   );

   assign pready = access;
   assign pslverr = access & ~anyHit;

   // Read data is latched in the setup cycle so it is stable through access
   always_ff @(posedge ref_clk) begin
      if (!rst_b) prdata <= 32'h00000000;
      else if (setupPhase && !pwrite) prdata <= readMux;
   end

   // Control registers; software keeps them still while the unit runs
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         serial_control_zero <= `UDE_CTL0_RST;
         serial_control_one <= `UDE_CTL1_RST;
         baudDiv <= `UDE_BAUD_RST;
      end else if (wrOk) begin
         if (hitCtl0) serial_control_zero <= pwdata[7:0];
         if (hitCtl1) serial_control_one <= pwdata[7:0];
         if (hitBaudH) baudDiv[15:8] <= pwdata[7:0];
         if (hitBaudL) baudDiv[7:0] <= pwdata[7:0];
      end
   end

   // Holding register: a new write wins over the load that empties it
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         txHold <= 8'h00;
         txFull <= 1'b0;
      end else if (txWrite) begin
         txHold <= pwdata[7:0];
         txFull <= 1'b1;
      end else if (txLoad) begin
         txFull <= 1'b0;
      end
   end

   // Transmit sequencing
   always_comb begin
      next_txState = txState;
      unique case (txState)
         uart_de_pkg::TX_IDLE: if (txGo) next_txState = uart_de_pkg::TX_SETUP;
         // Seventeen ticks from a free-running divider: over one bit, under two
         uart_de_pkg::TX_SETUP: if (txBitEnd) next_txState = uart_de_pkg::TX_START;
         uart_de_pkg::TX_START: if (txBitEnd) next_txState = uart_de_pkg::TX_DATA;
         uart_de_pkg::TX_DATA: begin
            if (txBitEnd && txBitIdx == `UDE_DATA_LAST) begin
               if (mpOn) next_txState = uart_de_pkg::TX_MP;
               else if (parity_on) next_txState = uart_de_pkg::TX_PARITY;
               else next_txState = uart_de_pkg::TX_STOP;
            end
         end
         uart_de_pkg::TX_MP: begin
            if (txBitEnd) begin
               next_txState = parity_on ? uart_de_pkg::TX_PARITY : uart_de_pkg::TX_STOP;
            end
         end
         uart_de_pkg::TX_PARITY: if (txBitEnd) next_txState = uart_de_pkg::TX_STOP;
         uart_de_pkg::TX_STOP: begin
            // A waiting byte goes straight to its start bit, envelope kept on
            if (stopEnd) next_txState = txGo ? uart_de_pkg::TX_START
                                             : uart_de_pkg::TX_DONE;
         end
         uart_de_pkg::TX_DONE: next_txState = uart_de_pkg::TX_IDLE;
      endcase
   end

   // Transmit state and bit timing
   always_ff @(posedge ref_clk) begin
      if (!rst_b) txState <= uart_de_pkg::TX_IDLE;
      else txState <= next_txState;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b || txState == uart_de_pkg::TX_IDLE || txBitEnd) subCnt <= 5'h00;
      else if (sampleTick) subCnt <= subCnt + 5'h01;
   end

   // Shift register, parity and counters of the byte on the wire
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         txShift <= 8'h00;
         txParity <= 1'b0;
         txBitIdx <= 3'h0;
         txSecondStop <= 1'b0;
      end else if (txLoad) begin
         txShift <= txHold;
         txParity <= (^txHold) ^ parOdd;
         txBitIdx <= 3'h0;
         txSecondStop <= 1'b0;
      end else if (txBitEnd) begin
         if (txState == uart_de_pkg::TX_DATA) begin
            txShift <= {1'b0, txShift[7:1]};
            txBitIdx <= txBitIdx + 3'h1;
         end
         if (txState == uart_de_pkg::TX_STOP) txSecondStop <= 1'b1;
      end
   end

   // Line level per state; idle, setup and tail rest at mark
   wire logic lineBit =
      (txState == uart_de_pkg::TX_START) ? 1'b0 :
      (txState == uart_de_pkg::TX_DATA) ? txShift[0] :
      (txState == uart_de_pkg::TX_MP) ? mpSend :
      (txState == uart_de_pkg::TX_PARITY) ? txParity : 1'b1;

   // Line and envelope share one flop stage so their relative timing is exact
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         txd <= 1'b1;
         tx_driver_enable <= 1'b0;
      end else begin
         txd <= lineBit & ~send_break;
         tx_driver_enable <= deActive ^ driver_enable_polarity;
      end
   end

   // Receive sequencing at sixteen samples per bit
   always_ff @(posedge ref_clk) begin
      if (!rst_b || !rxOn) begin
         rxState <= uart_de_pkg::RX_IDLE;
      end else begin
         unique case (rxState)
            uart_de_pkg::RX_IDLE: if (!rxIn) rxState <= uart_de_pkg::RX_START;
            uart_de_pkg::RX_START: begin
               // A glitch shorter than half a bit is dropped here
               if (rxSample) rxState <= rxIn ? uart_de_pkg::RX_IDLE : uart_de_pkg::RX_DATA;
            end
            uart_de_pkg::RX_DATA: begin
               if (rxSample && rxBitIdx == `UDE_DATA_LAST) begin
                  if (mpOn) rxState <= uart_de_pkg::RX_MP;
                  else if (parity_on) rxState <= uart_de_pkg::RX_PARITY;
                  else rxState <= uart_de_pkg::RX_STOP;
               end
            end
            uart_de_pkg::RX_MP: begin
               if (rxSample) begin
                  rxState <= parity_on ? uart_de_pkg::RX_PARITY : uart_de_pkg::RX_STOP;
               end
            end
            uart_de_pkg::RX_PARITY: if (rxSample) rxState <= uart_de_pkg::RX_STOP;
            uart_de_pkg::RX_STOP: if (rxSample) rxState <= uart_de_pkg::RX_IDLE;
            default: rxState <= uart_de_pkg::RX_IDLE;
         endcase
      end
   end

   // Receive sample counter and byte assembly
   always_ff @(posedge ref_clk) begin
      if (!rst_b || rxState == uart_de_pkg::RX_IDLE) begin
         rxSub <= 5'h00;
         rxBitIdx <= 3'h0;
         rxParAcc <= 1'b0;
         rxParBad <= 1'b0;
         rxMpBit <= 1'b0;
         if (!rst_b) rxShift <= 8'h00;
      end else if (rxSample) begin
         rxSub <= 5'h00;
         if (rxState == uart_de_pkg::RX_DATA) begin
            rxShift <= {rxIn, rxShift[7:1]};
            rxBitIdx <= rxBitIdx + 3'h1;
            rxParAcc <= rxParAcc ^ rxIn;
         end
         if (rxState == uart_de_pkg::RX_MP) rxMpBit <= rxIn;
         if (rxState == uart_de_pkg::RX_PARITY) rxParBad <= rxParAcc ^ rxIn ^ parOdd;
      end else if (sampleTick) begin
         rxSub <= rxSub + 5'h01;
      end
   end

   // Receive status: a byte landing in the read cycle wins over the clear
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rxData <= 8'h00;
         rxReady <= 1'b0;
         parityErr <= 1'b0;
         framingErr <= 1'b0;
         overrun <= 1'b0;
         first_byte_of_frame_flag <= 1'b0;
         multiproc_bit_received <= 1'b0;
      end else if (rxStore) begin
         rxData <= rxShift;
         rxReady <= 1'b1;
         parityErr <= rxParBad;
         framingErr <= ~rxIn;
         overrun <= rxReady & ~rxRead;
         first_byte_of_frame_flag <= mpOn & rxMpBit;
         multiproc_bit_received <= mpOn & rxMpBit;
      end else if (rxRead) begin
         rxReady <= 1'b0;
         parityErr <= 1'b0;
         framingErr <= 1'b0;
         overrun <= 1'b0;
         first_byte_of_frame_flag <= 1'b0;
         multiproc_bit_received <= 1'b0;
      end
   end

   // Guard against clearing a byte that arrived after its data was latched
   always_ff @(posedge ref_clk) begin
      if (!rst_b) skipClear <= 1'b0;
      else if (setupPhase) skipClear <= rxStore;
   end

   // Timer mode: each divider period sets the flag, status read clears it
   always_ff @(posedge ref_clk) begin
      if (!rst_b) timerFlag <= 1'b0;
      else if (timerMode && sampleTick) timerFlag <= 1'b1;
      else if (statRead) timerFlag <= 1'b0;
   end

   // Two interrupt lines, level until serviced
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         txIrq <= 1'b0;
         rxIrq <= 1'b0;
      end else begin
         txIrq <= transmitter_on & ~txFull;
         rxIrq <= (rxOn & rxReady) | timerFlag;
      end
   end

   // Cycles the envelope has been on, for the setup-time check
   logic [23:0] deCycles;
   always_ff @(posedge ref_clk) begin
      if (!rst_b || !deActive) deCycles <= 24'h000000;
      else if (deCycles != 24'hffffff) deCycles <= deCycles + 24'h000001;
   end
   wire logic [23:0] oneBit = {4'h0, baudDiv, 4'h0};

   // Parity of the data bits already shifted onto the line, kept apart from txParity
   logic sentPar;
   always_ff @(posedge ref_clk) begin
      if (!rst_b || txLoad) sentPar <= 1'b0;
      else if (txBitEnd && txState == uart_de_pkg::TX_DATA) sentPar <= sentPar ^ txShift[0];
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_de_setup_time: assert property (
      (txState == uart_de_pkg::TX_SETUP && next_txState == uart_de_pkg::TX_START
       && baudDiv != 16'h0000)
      |-> (deCycles + 24'h000001 >= oneBit) && (deCycles + 24'h000001 < {oneBit[22:0], 1'b0}))
      else $error("driver enable setup outside one to two bits");
   a_de_tail_drop: assert property (
      (stopEnd && !txGo) |=> deActive ##1 !deActive)
      else $error("driver enable did not drop one clock after stop");
   a_de_back_to_back: assert property (
      (stopEnd && txGo) |=> (txState == uart_de_pkg::TX_START) && deActive)
      else $error("driver enable broke between characters");
   a_write_raises_de: assert property (
      (txWrite && txState == uart_de_pkg::TX_IDLE && transmitter_on && ctsOk && !txFull)
      |-> ##[1:2] deActive)
      else $error("transmit write did not raise driver enable");
   a_frame_envelope: assert property (
      (txState == uart_de_pkg::TX_START) |=> tx_driver_enable == ~driver_enable_polarity
      || $past(driver_enable_polarity) != driver_enable_polarity)
      else $error("driver enable inactive during frame");
   a_idle_mark: assert property (
      (txState == uart_de_pkg::TX_IDLE && !send_break) ##1 !send_break |-> txd
      && tx_driver_enable == $past(driver_enable_polarity))
      else $error("idle line not at mark or enable active");
   a_cts_blocks: assert property (
      (txState == uart_de_pkg::TX_IDLE && clear_to_send_gating && cts_b)
      |=> txState == uart_de_pkg::TX_IDLE)
      else $error("transmit started while clear to send high");
   a_tx_disabled: assert property (
      (txState == uart_de_pkg::TX_IDLE && !transmitter_on) |=> txState == uart_de_pkg::TX_IDLE)
      else $error("transmit started while disabled");
   a_rx_disabled: assert property (
      !rxOn |=> rxState == uart_de_pkg::RX_IDLE && !rxStore)
      else $error("receiver ran while disabled");
   a_read_clears: assert property (
      (rxRead && !rxStore) |=> !first_byte_of_frame_flag && !multiproc_bit_received && !rxReady)
      else $error("data read left frame flags set");
   a_mp_capture: assert property (
      (rxStore && mpOn) |=> multiproc_bit_received == $past(rxMpBit))
      else $error("multiprocessor bit not captured");
   a_tx_parity: assert property (
      (txState == uart_de_pkg::TX_PARITY && !send_break)
      |=> txd == ($past(sentPar) ^ $past(parOdd)))
      else $error("parity bit wrong");
   a_reserved_zero: assert property (
      (setupPhase && !pwrite && hitStat) |=> prdata[31:9] == 23'h000000)
      else $error("reserved status bits not zero");
   a_ctl_reset: assert property (
      $rose(rst_b) |-> serial_control_zero == `UDE_CTL0_RST)
      else $error("control zero not reset");
   a_timer_event: assert property (
      (timerMode && sampleTick) |=> timerFlag ##1 rxIrq)
      else $error("timer did not raise receive interrupt");
   a_tx_irq: assert property (
      (transmitter_on && !txFull) |=> txIrq)
      else $error("transmit interrupt missing");
endmodule

// ==== hdl/uart_de_regs.svh ====
// Register indices, field positions, reset values and bit timing counts
`ifndef UART_DE_REGS_SVH
`define UART_DE_REGS_SVH

// Register indices; the APB byte address is four times the index
`define UDE_DATA_IDX 14'h0f40
`define UDE_STAT_IDX 14'h0f41
`define UDE_CTL0_IDX 14'h0f42
`define UDE_CTL1_IDX 14'h0f43
`define UDE_BAUDH_IDX 14'h0f46
`define UDE_BAUDL_IDX 14'h0f47

// serial_control_zero fields
`define UDE_TXON 7
`define UDE_RXON 6
`define UDE_CTSG 5
`define UDE_PARON 4
`define UDE_PARODD 3
`define UDE_BRK 2
`define UDE_STOP2 1
`define UDE_LOOP 0

// Second control register fields
`define UDE_DRIVER_ENABLE_POLARITY 0
`define UDE_MPON 1
`define UDE_MPSEND 2
`define UDE_TIMERON 3

// Reset values
`define UDE_CTL0_RST 8'h00
`define UDE_CTL1_RST 8'h00
`define UDE_BAUD_RST 16'h0004

// Sample-tick counts: 16 ticks per bit, setup waits 17, receive mid-bit at 8
`define UDE_BIT_LAST 5'h0f
`define UDE_SETUP_LAST 5'h10
`define UDE_RX_MID 5'h07
`define UDE_DATA_LAST 3'h7

`endif

// ==== hdl/uart_de_pkg.sv ====
// Types shared by the serial driver-enable control design
package uart_de_pkg;
   typedef enum logic [2:0] {
      TX_IDLE, TX_SETUP, TX_START, TX_DATA, TX_MP, TX_PARITY, TX_STOP, TX_DONE
   } tx_state_e;
   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_MP, RX_PARITY, RX_STOP
   } rx_state_e;
endpackage

// ==== hdl/uart_baud_tick.sv ====
// Baud divider giving a one-cycle sample enable every divisor clocks
`timescale 1ns/100ps
module uart_baud_tick (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Divisor, zero is treated as one
   input wire logic [15:0] divisor,
   // One-cycle enable at sixteen times the bit rate
   output logic sampleTick
);
   logic [15:0] count; // Cycles since last tick
   wire logic [15:0] lastCount = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
   wire logic atLast = (count >= lastCount);

   // Free-running divider; a lowered divisor ends the period at once
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         count <= 16'h0000;
         sampleTick <= 1'b0;
      end else begin
         count <= atLast ? 16'h0000 : count + 16'h0001;
         sampleTick <= atLast;
      end
   end
endmodule

// ==== verif/rs485_node.sv ====
// Remote node on the shared serial bus, sending frames into the receiver
`timescale 1ns/100ps
module rs485_node #(parameter int BIT = 16) (
   // Clock
   input wire logic ref_clk,
   // Line towards the receiver
   output logic rxd
);
   // Failsafe bias holds the released bus at mark
   initial rxd = 1'b1;
   // Start bit, data LSB first with mp bit as bit 8, then stop; n counts all bits
   task automatic send(input logic [8:0] f, input int n);
      int i;
      int j;
      for (i = 0; i < n; i++) begin
         for (j = 0; j < BIT; j++) begin
            @(posedge ref_clk);
            rxd <= (i == 0) ? 1'b0 : (i == n - 1) ? 1'b1 : f[i - 1];
         end
      end
   endtask
endmodule

// ==== verif/uart_driver_enable_control_test.sv ====
// Self-checking bench for the driver-enable serial slice over APB
`timescale 1ns/100ps
`include "uart_de_regs.svh"
module uart_driver_enable_control_test;
   logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, cts_b = 1;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, txd, rxd, tx_driver_enable, txIrq, rxIrq, err;
   int n_errors = 0, checks = 0, n, st, run, i;
   logic [11:0] bits;
   uart_driver_enable_control uart_driver_enable_control_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd),
      .cts_b(cts_b), .tx_driver_enable(tx_driver_enable), .txIrq(txIrq), .rxIrq(rxIrq));
   rs485_node #(.BIT(16)) rs485_node_i (.ref_clk(ref_clk), .rxd(rxd));
   // 125 MHz clock
   initial forever #4 ref_clk = ~ref_clk;
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h", $time, m, got);
      end
   endtask
   // A wait that ran out ends the run
   task automatic guard(input int lim);
      if (n >= lim) begin
         chk(0, 1, "wait ran out");
         end_of_test();
      end
   endtask
   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      guard(20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Control changes only with the unit off; reserved bits written as zero
   task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
      apb(1, `UDE_CTL0_IDX, 32'h0);
      apb(1, `UDE_CTL1_IDX, {24'h0, c1});
      apb(1, `UDE_CTL0_IDX, {24'h0, c0});
   endtask
   // Watch one envelope: setup length, active length, mid-bit samples of txd
   task automatic frame(input logic act);
      for (n = 0; n < 4 && tx_driver_enable !== act; n++) @(posedge ref_clk);
      guard(4);
      st = -1;
      bits = '1;
      for (run = 0; run < 2000 && tx_driver_enable === act; run++) begin
         if (st < 0 && txd === 1'b0) st = run;
         if (st >= 0 && (run - st) % 16 == 8 && (run - st) / 16 < 12) bits[(run - st) / 16] = txd;
         @(posedge ref_clk);
      end
   endtask
   task automatic txchk(input logic [7:0] d, input logic act, input int nb, input logic b9);
      frame(act);
      chk(st >= 16 && st <= 32, 1, "setup time");
      chk(run - st, nb * 16 + 1, "envelope end");
      chk(bits[9:0], {b9, d, 1'b0}, "frame bits");
   endtask
   logic [7:0] modes [4] = '{8'h80, 8'h90, 8'h98, 8'h82};
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      apb(0, `UDE_CTL0_IDX, 0);
      chk(q, 32'h0, "control zero reset");
      apb(0, 14'h0f44, 0);
      chk(err, 1, "unmapped error");
      chk(q, 32'h0, "unmapped read");
      chk({txd, tx_driver_enable}, 2'b10, "idle line");
      apb(1, `UDE_BAUDH_IDX, 0);
      apb(1, `UDE_BAUDL_IDX, 1);
      apb(1, `UDE_DATA_IDX, 32'h3c);
      repeat (40) @(posedge ref_clk);
      chk(tx_driver_enable, 0, "tx off stays quiet");
      cfg(8'ha0, 8'h00);
      repeat (40) @(posedge ref_clk);
      chk(tx_driver_enable, 0, "cts gating holds");
      cts_b <= 1'b0;
      txchk(8'h3c, 1, 10, 1);
      $display("test gating done");
      for (i = 0; i < 4; i++) begin
         cfg(modes[i], 8'h00);
         repeat (2) @(posedge ref_clk);
         chk(txIrq, 1, "tx irq");
         apb(1, `UDE_DATA_IDX, 32'h55);
         txchk(8'h55, 1, i ? 11 : 10, i != 1);
      end
      $display("test formats done");
      cfg(8'h80, 8'h01);
      chk(tx_driver_enable, 1, "inverted idle");
      apb(1, `UDE_DATA_IDX, 32'h81);
      for (n = 0; n < 100 && txIrq !== 1'b1; n++) @(posedge ref_clk);
      guard(100);
      apb(1, `UDE_DATA_IDX, 32'h7e);
      frame(0);
      chk(run - st >= 321, 1, "back to back envelope");
      chk(bits, 12'h302, "first of pair");
      $display("test back to back done");
      cfg(8'h00, 8'h02);
      rs485_node_i.send(9'h1a3, 11);
      chk(rxIrq, 0, "rx off ignores");
      cfg(8'h40, 8'h02);
      rs485_node_i.send(9'h1a3, 11);
      for (n = 0; n < 40 && rxIrq !== 1'b1; n++) @(posedge ref_clk);
      guard(40);
      apb(0, `UDE_STAT_IDX, 0);
      chk(q & 32'hffff_ffc1, 32'hc1, "status after frame");
      apb(0, `UDE_DATA_IDX, 0);
      chk(q, 32'ha3, "received byte");
      apb(0, `UDE_STAT_IDX, 0);
      chk(q & 32'hffff_ffc1, 32'h0, "flags cleared");
      $display("test receive done");
      // Loopback with the multiprocessor bit sent and received
      cfg(8'hc1, 8'h06);
      apb(1, `UDE_DATA_IDX, 32'h5a);
      txchk(8'h5a, 1, 11, 1);
      apb(0, `UDE_STAT_IDX, 0);
      chk(q & 32'hc1, 32'hc1, "looped status");
      apb(0, `UDE_DATA_IDX, 0);
      chk(q, 32'h5a, "looped byte");
      cfg(8'h84, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk(txd, 0, "break holds line low");
      $display("test loopback done");
      cfg(8'h00, 8'h08);
      for (n = 0; n < 40 && rxIrq !== 1'b1; n++) @(posedge ref_clk);
      guard(40);
      apb(0, `UDE_STAT_IDX, 0);
      chk(q[8], 1, "timer flag");
      $display("test timer done");
      end_of_test();
   end
endmodule
